// [hw/fcbu_branch.sv]
/*
  fcbu_branch: decode and execute of the sign-clear, nonzero and sign-set conditional jumps.
  Assumes the fetch path offers an opcode byte with its address, program memory answers a read
  one cycle after the request, and the program counter takes PROGRAM_COUNTER_LOAD with PROGRAM_COUNTER_VALUE.
*/
`timescale 1ns/10ps
// Contract
// (RULE1) jump-if-sign-clear opcode branches only when sign flag is zero
// (RULE2) jump-if-nonzero opcode branches only when zero flag is zero
// (RULE3) jump-if-sign-set opcode branches only when sign flag is one
// (RULE4) taken branch loads program counter with target, fetching continues there
// (RULE5) branch not taken continues at the instruction three bytes on
// (RULE6) each jump takes eleven cycles when taken, ten when not
// (RULE7) target is the two following bytes, high byte first
// (RULE8) zero flag set by zero arithmetic result, cleared by nonzero
// (RULE9) these jumps leave zero, carry and sign flags unchanged
module fcbu_branch (
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  input  wire logic        INSTR_VALID,
  input  wire logic [7:0]  INSTR_OPCODE,
  input  wire logic [15:0] INSTR_ADDR,
  output logic             INSTR_BUSY,
  output logic             MEM_RD_EN,
  output logic [15:0]      MEM_ADDR,
  input  wire logic [7:0]  MEM_RDATA,
  output logic             PROGRAM_COUNTER_LOAD,
  output logic [15:0]      PROGRAM_COUNTER_VALUE,
  output logic             BRANCH_TAKEN,
  input  wire logic        ALU_WE,
  input  wire logic [7:0]  ALU_RESULT,
  input  wire logic        ALU_CARRY,
  input  wire logic        ALU_SIGN_WE,
  input  wire logic        ALU_SIGN,
  output logic             FLAG_Z,
  output logic             FLAG_C,
  output logic             FLAG_S
);
  fcbu_pkg::fcbu_state_t state_r;
  fcbu_pkg::fcbu_state_t state_nxt;
  logic [3:0]            cnt_r;
  logic [15:0]           base_r;
  logic [7:0]            tgt_hi_r;
  logic [7:0]            tgt_lo_r;
  logic                  taken_r;
  logic                  busy_r;
  logic                  rd_r;
  logic [15:0]           rd_addr_r;
  logic                  done_r;
  logic [15:0]           load_value_r;
  logic                  is_sign_clr;
  logic                  is_nonzero;
  logic                  is_sign_set;
  logic                  accept;
  logic                  cond;
  logic                  idle;
  logic                  exec;
  logic                  last;
  logic [3:0]            cnt_last;
  logic [15:0]           target;
  logic [15:0]           fall_through;

  // decoder shared by acceptance and the assertions
  function automatic logic opc_is(input logic [7:0] opc, input logic [7:0] code);
    opc_is = (opc == code);
  endfunction

  // flag register; this unit has no write path into it, so jumps cannot disturb it
  fcbu_flags u_flags (
    .clk_sys     (CLK_SYS),
    .rstn        (RSTN),
    .alu_we      (ALU_WE),
    .alu_result  (ALU_RESULT),
    .alu_carry   (ALU_CARRY),
    .alu_sign_we (ALU_SIGN_WE),
    .alu_sign    (ALU_SIGN),
    .flag_z_r    (FLAG_Z),
    .flag_c_r    (FLAG_C),
    .flag_s_r    (FLAG_S)
  ); // RULE9

  // opcode decode and branch condition, sampled on the accept edge only
  assign idle         = (state_r == fcbu_pkg::FCBU_IDLE);
  assign exec         = (state_r == fcbu_pkg::FCBU_EXEC);
  assign is_sign_clr  = opc_is(INSTR_OPCODE, fcbu_pkg::OPC_JP_SIGN_CLR);
  assign is_nonzero   = opc_is(INSTR_OPCODE, fcbu_pkg::OPC_JP_NONZERO);
  assign is_sign_set  = opc_is(INSTR_OPCODE, fcbu_pkg::OPC_JP_SIGN_SET);
  assign accept       = idle && INSTR_VALID && (is_sign_clr || is_nonzero || is_sign_set);
  assign cond         = (is_sign_clr && !FLAG_S)  // RULE1
                      || (is_nonzero && !FLAG_Z)  // RULE2
                      || (is_sign_set && FLAG_S); // RULE3
  // cycle budget chosen per outcome; the taken path spends one more cycle
  assign cnt_last     = taken_r ? fcbu_pkg::CNT_LAST_TAKEN : fcbu_pkg::CNT_LAST_NOT; // RULE6
  assign last         = exec && (cnt_r == cnt_last) && !done_r;
  assign target       = {tgt_hi_r, tgt_lo_r}; // RULE7
  assign fall_through = base_r + fcbu_pkg::INSTR_BYTES; // RULE5

  // idle waits for a handled opcode; exec leaves after the done cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fcbu_pkg::FCBU_IDLE: begin
        if (accept) state_nxt = fcbu_pkg::FCBU_EXEC;
      end
      fcbu_pkg::FCBU_EXEC: begin
        if (done_r) state_nxt = fcbu_pkg::FCBU_IDLE;
      end
      default: state_nxt = fcbu_pkg::FCBU_IDLE;
    endcase
  end

  // sequencing: state, cycle counter and latched decision
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      state_r <= fcbu_pkg::FCBU_IDLE;
      cnt_r   <= fcbu_pkg::RST_CNT;
      taken_r <= 1'b0;
      base_r  <= fcbu_pkg::RST_ADDR;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= accept ? fcbu_pkg::RST_CNT : cnt_r + 4'h1;
      if (accept) begin
        taken_r <= cond;
        base_r  <= INSTR_ADDR;
      end
      busy_r  <= accept || (exec && !done_r);
      done_r  <= last; // RULE6
    end
  end

  // operand reads: high byte address first, then low; data lands one cycle later
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      rd_r      <= 1'b0;
      rd_addr_r <= fcbu_pkg::RST_ADDR;
    end else begin
      rd_r      <= accept || (exec && cnt_r == fcbu_pkg::CNT_RD_LO);
      if (accept) rd_addr_r <= INSTR_ADDR + fcbu_pkg::OFS_TGT_HI; // RULE7
      else if (exec && cnt_r == fcbu_pkg::CNT_RD_LO) rd_addr_r <= base_r + fcbu_pkg::OFS_TGT_LO;
    end
  end

  // target capture; the bytes are fetched even when unused, to keep timing fixed
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      tgt_hi_r <= fcbu_pkg::RST_BYTE;
      tgt_lo_r <= fcbu_pkg::RST_BYTE;
    end else begin
      if (exec && cnt_r == fcbu_pkg::CNT_CAP_HI) tgt_hi_r <= MEM_RDATA; // RULE7
      if (exec && cnt_r == fcbu_pkg::CNT_CAP_LO) tgt_lo_r <= MEM_RDATA; // RULE7
    end
  end

  // next program counter value, valid with the load pulse
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      load_value_r <= fcbu_pkg::RST_ADDR;
    end else if (last) begin
      load_value_r <= taken_r ? target : fall_through; // RULE4 RULE5
    end
  end

  // outputs straight from their flip-flops, no decode on the way out
  assign INSTR_BUSY            = busy_r;
  assign MEM_RD_EN             = rd_r;
  assign MEM_ADDR              = rd_addr_r;
  assign PROGRAM_COUNTER_LOAD  = done_r;
  assign PROGRAM_COUNTER_VALUE = load_value_r;
  assign BRANCH_TAKEN          = taken_r;

  property p_sign_clr;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (accept && opc_is(INSTR_OPCODE, fcbu_pkg::OPC_JP_SIGN_CLR)) |=> (taken_r == !$past(FLAG_S));
  endproperty
  a_sign_clr: assert property (p_sign_clr) else $error("sign-clear jump decision wrong"); // RULE1

  property p_nonzero;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (accept && opc_is(INSTR_OPCODE, fcbu_pkg::OPC_JP_NONZERO)) |=> (taken_r == !$past(FLAG_Z));
  endproperty
  a_nonzero: assert property (p_nonzero) else $error("nonzero jump decision wrong"); // RULE2

  property p_sign_set;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (accept && opc_is(INSTR_OPCODE, fcbu_pkg::OPC_JP_SIGN_SET)) |=> (taken_r == $past(FLAG_S));
  endproperty
  a_sign_set: assert property (p_sign_set) else $error("sign-set jump decision wrong"); // RULE3

  property p_load_target;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (PROGRAM_COUNTER_LOAD && taken_r) |->
        (PROGRAM_COUNTER_VALUE == {tgt_hi_r, tgt_lo_r}) ##1 (!PROGRAM_COUNTER_LOAD && !INSTR_BUSY);
  endproperty
  a_load_target: assert property (p_load_target) else $error("taken jump loaded wrong address"); // RULE4

  property p_fall_through;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (PROGRAM_COUNTER_LOAD && !taken_r) |-> (PROGRAM_COUNTER_VALUE == base_r + fcbu_pkg::INSTR_BYTES);
  endproperty
  a_fall_through: assert property (p_fall_through) else $error("not-taken jump skipped wrongly"); // RULE5

  sequence s_quiet9;
    !PROGRAM_COUNTER_LOAD [*8] ##1 !PROGRAM_COUNTER_LOAD;
  endsequence

  property p_cyc_taken;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (accept && cond) |=> s_quiet9 ##1 PROGRAM_COUNTER_LOAD;
  endproperty
  a_cyc_taken: assert property (p_cyc_taken) else $error("taken jump not eleven cycles"); // RULE6

  property p_cyc_not;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (accept && !cond) |=> !PROGRAM_COUNTER_LOAD [*8] ##1 PROGRAM_COUNTER_LOAD;
  endproperty
  a_cyc_not: assert property (p_cyc_not) else $error("not-taken jump not ten cycles"); // RULE6

  sequence s_operand_reads;
    MEM_RD_EN && (MEM_ADDR == base_r + fcbu_pkg::OFS_TGT_HI)
      ##1 MEM_RD_EN && (MEM_ADDR == base_r + fcbu_pkg::OFS_TGT_LO);
  endsequence

  property p_target_order;
    @(posedge CLK_SYS) disable iff (!RSTN)
      accept |=> s_operand_reads ##1 (tgt_hi_r == $past(MEM_RDATA)) ##1 (tgt_lo_r == $past(MEM_RDATA));
  endproperty
  a_target_order: assert property (p_target_order) else $error("target bytes read out of order"); // RULE7

  property p_jump_keeps_flags;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (INSTR_BUSY && !ALU_WE && !ALU_SIGN_WE) |=> $stable({FLAG_Z, FLAG_C, FLAG_S});
  endproperty
  a_jump_keeps_flags: assert property (p_jump_keeps_flags) else $error("jump disturbed flags"); // RULE9
endmodule

// [hw/fcbu_pkg.sv]
/*
  fcbu_pkg: constants shared by the flag-conditional branch unit and its flag register.
  Assumes one 250 MHz core clock and byte-wide program memory with one-cycle read latency.
*/
package fcbu_pkg;
  // opcode bytes of the three handled jumps
  localparam logic [7:0]  OPC_JP_SIGN_CLR = 8'h42;
  localparam logic [7:0]  OPC_JP_NONZERO  = 8'h44;
  localparam logic [7:0]  OPC_JP_SIGN_SET = 8'h41;
  // instruction length in bytes, and operand offsets from the opcode address
  localparam logic [15:0] INSTR_BYTES     = 16'h0003;
  localparam logic [15:0] OFS_TGT_HI      = 16'h0001;
  localparam logic [15:0] OFS_TGT_LO      = 16'h0002;
  // occupancy in clock cycles, accept cycle through done cycle
  localparam int          CYC_TAKEN       = 11;
  localparam int          CYC_NOT_TAKEN   = 10;
  // counter width, and counter values at which done is scheduled (done shows one cycle later) and operands are read and captured
  localparam logic [3:0]  CNT_W           = 4'h4;
  localparam logic [3:0]  CNT_LAST_TAKEN  = 4'(CYC_TAKEN - 3);
  localparam logic [3:0]  CNT_LAST_NOT    = 4'(CYC_NOT_TAKEN - 3);
  localparam logic [3:0]  CNT_CAP_HI      = 4'h1;
  localparam logic [3:0]  CNT_CAP_LO      = 4'h2;
  localparam logic [3:0]  CNT_RD_LO       = 4'h0;
  // reset values
  localparam logic [15:0] RST_ADDR        = 16'h0000;
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [3:0]  RST_CNT         = 4'h0;
  localparam logic        RST_FLAG        = 1'b0;

  typedef enum logic [1:0] {
    FCBU_IDLE = 2'b01,
    FCBU_EXEC = 2'b10
  } fcbu_state_t;
endpackage

// [hw/fcbu_flags.sv]
/*
  fcbu_flags: zero, carry and sign flag register of the core.
  Assumes the arithmetic unit presents its result with one-cycle write strobes; jumps never write here.
*/
`timescale 1ns/10ps
module fcbu_flags (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       alu_we,
  input  wire logic [7:0] alu_result,
  input  wire logic       alu_carry,
  input  wire logic       alu_sign_we,
  input  wire logic       alu_sign,
  output logic            flag_z_r,
  output logic            flag_c_r,
  output logic            flag_s_r
);
  logic result_zero;

  // zero is derived here, not by the caller, so it cannot disagree with the result
  assign result_zero = (alu_result == fcbu_pkg::RST_BYTE); // RULE8

  // flags move only on an arithmetic strobe; nothing else has a write path
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      flag_z_r <= fcbu_pkg::RST_FLAG;
      flag_c_r <= fcbu_pkg::RST_FLAG;
      flag_s_r <= fcbu_pkg::RST_FLAG;
    end else begin
      if (alu_we) begin
        flag_z_r <= result_zero; // RULE8
        flag_c_r <= alu_carry;
      end
      if (alu_sign_we) begin
        flag_s_r <= alu_sign;
      end
    end
  end

  property p_zero_from_result;
    @(posedge clk_sys) disable iff (!rstn)
      alu_we |=> (flag_z_r == ($past(alu_result) == 8'h00));
  endproperty
  a_zero_from_result: assert property (p_zero_from_result) else $error("zero flag does not follow result"); // RULE8

  property p_flags_hold;
    @(posedge clk_sys) disable iff (!rstn)
      (!alu_we && !alu_sign_we) |=> $stable({flag_z_r, flag_c_r, flag_s_r});
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags changed without arithmetic write"); // RULE9
endmodule

// [test/fcbu_prog_mem.sv]
/*
  fcbu_prog_mem: behavioural program memory facing the branch unit's operand reads.
  Assumes reads are one-cycle strobes and data is wanted the cycle after the strobe.
*/
`timescale 1ns/10ps
module fcbu_prog_mem (
  input  wire logic        clk_sys,
  input  wire logic        rd_en,
  input  wire logic [15:0] addr,
  output logic      [7:0]  rdata
);
  initial rdata = 8'h00;

  // contents follow the address so hi and lo bytes differ at every address the bench reads;
  // between reads the bus toggles, so a late sample never sees stale data
  always @(posedge clk_sys) begin
    if (rd_en) begin
      rdata <= (addr[7:0] + 8'h3C) ^ addr[15:8];
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule

// [test/tb.sv]
/*
  tb: self-checking bench for the flag-conditional branch unit.
  Assumes a 250 MHz clock, synchronous active-low reset and the program memory model beside it.
*/
`timescale 1ns/10ps
module tb;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        instr_valid = 1'b0;
  logic [7:0]  instr_opcode = 8'h00;
  logic [15:0] instr_addr = 16'h0000;
  logic        alu_we = 1'b0;
  logic [7:0]  alu_result = 8'h00;
  logic        alu_carry = 1'b0;
  logic        alu_sign_we = 1'b0;
  logic        alu_sign = 1'b0;
  logic        instr_busy, mem_rd_en, counter_load, branch_taken, flag_z, flag_c, flag_s;
  logic [15:0] mem_addr, counter_value;
  logic [7:0]  mem_rdata;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;

  always #2 clk_sys = ~clk_sys;

  fcbu_branch u_fcbu_branch (.CLK_SYS(clk_sys), .RSTN(rstn), .INSTR_VALID(instr_valid),
    .INSTR_OPCODE(instr_opcode), .INSTR_ADDR(instr_addr), .INSTR_BUSY(instr_busy),
    .MEM_RD_EN(mem_rd_en), .MEM_ADDR(mem_addr), .MEM_RDATA(mem_rdata),
    .PROGRAM_COUNTER_LOAD(counter_load), .PROGRAM_COUNTER_VALUE(counter_value),
    .BRANCH_TAKEN(branch_taken), .ALU_WE(alu_we), .ALU_RESULT(alu_result),
    .ALU_CARRY(alu_carry), .ALU_SIGN_WE(alu_sign_we), .ALU_SIGN(alu_sign), .FLAG_Z(flag_z),
    .FLAG_C(flag_c), .FLAG_S(flag_s));

  fcbu_prog_mem u_fcbu_prog_mem (.clk_sys(clk_sys), .rd_en(mem_rd_en), .addr(mem_addr), .rdata(mem_rdata));

  task test_done;
    $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // hang guard: about 120 cycles are needed, ceiling well above
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      test_done;
    end
  end

  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // single-bit compare, widened on purpose to the common compare width
  task chk1(input string name, input logic exp, input logic got);
    chk(name, {15'h0000, exp}, {15'h0000, got});
  endtask

  // every output at its reset value, flags included
  task chk_idle(input string name);
    chk({name, "_ctl"}, 16'h0000,
        {9'h000, instr_busy, mem_rd_en, counter_load, branch_taken, flag_z, flag_c, flag_s});
    chk({name, "_addr"}, 16'h0000, mem_addr);
    chk({name, "_load_value"}, 16'h0000, counter_value);
  endtask

  // one strobe cycle into the flag register, flags checked the cycle after
  task set_flags(input logic z, input logic s, input logic c, input logic [7:0] nz);
    @(posedge clk_sys); #1;
    alu_we = 1'b1; alu_sign_we = 1'b1; alu_result = z ? 8'h00 : nz; alu_carry = c; alu_sign = s;
    @(posedge clk_sys); #1;
    alu_we = 1'b0; alu_sign_we = 1'b0; alu_result = 8'h00;
    chk1("flag_z", z, flag_z);
    chk("flag_cs", {14'h0000, c, s}, {14'h0000, flag_c, flag_s});
  endtask

  // request is held through the busy cycles to show later requests are ignored
  task run_jump(input logic [7:0] opc, input logic [15:0] a, input logic tk);
    logic [15:0] hi_a, lo_a, r_hi, r_lo, tgt;
    logic [2:0]  fl;
    int          nrd, pcn;
    hi_a = a + 16'h0001;
    lo_a = a + 16'h0002;
    tgt = {(hi_a[7:0] + 8'h3C) ^ hi_a[15:8], (lo_a[7:0] + 8'h3C) ^ lo_a[15:8]};
    fl = {flag_z, flag_c, flag_s};
    nrd = 0;
    pcn = 0;
    r_hi = 16'h0000;
    r_lo = 16'h0000;
    @(posedge clk_sys); #1;
    instr_valid = 1'b1; instr_opcode = opc; instr_addr = a;
    @(posedge clk_sys); #1;
    chk1("busy", 1'b1, instr_busy);
    chk1("branch_taken", tk, branch_taken);
    for (int n = 1; n < 15 && pcn == 0; n++) begin
      if (mem_rd_en === 1'b1) begin
        if (nrd == 0) r_hi = mem_addr;
        else r_lo = mem_addr;
        nrd++;
      end
      if (counter_load === 1'b1) pcn = n;
      else begin
        @(posedge clk_sys); #1;
      end
    end
    instr_valid = 1'b0;
    chk("load_cycle", 16'((tk ? fcbu_pkg::CYC_TAKEN : fcbu_pkg::CYC_NOT_TAKEN) - 1), 16'(pcn));
    chk("reads", 16'h0002, 16'(nrd));
    chk("rd_hi", hi_a, r_hi);
    chk("rd_lo", lo_a, r_lo);
    chk("load_value", tk ? tgt : a + 16'h0003, counter_value);
    chk("flags", {13'h0000, fl}, {13'h0000, flag_z, flag_c, flag_s});
  endtask

  // sign clear: zero flag must not matter
  task t_sign_clear;
    set_flags(1'b1, 1'b0, 1'b1, 8'h01);
    run_jump(fcbu_pkg::OPC_JP_SIGN_CLR, 16'h09C3, 1'b1);
    set_flags(1'b0, 1'b1, 1'b0, 8'hFF);
    run_jump(fcbu_pkg::OPC_JP_SIGN_CLR, 16'h1234, 1'b0);
  endtask

  // nonzero, including fall-through wrapping past the top address
  task t_nonzero;
    set_flags(1'b0, 1'b1, 1'b1, 8'h80);
    run_jump(fcbu_pkg::OPC_JP_NONZERO, 16'hFFF0, 1'b1);
    set_flags(1'b1, 1'b0, 1'b0, 8'h00);
    run_jump(fcbu_pkg::OPC_JP_NONZERO, 16'hFFFD, 1'b0);
    run_jump(fcbu_pkg::OPC_JP_NONZERO, 16'h0000, 1'b0);
  endtask

  // sign set, back to back with the minimum spacing
  task t_sign_set;
    set_flags(1'b0, 1'b1, 1'b0, 8'h7F);
    run_jump(fcbu_pkg::OPC_JP_SIGN_SET, 16'h4000, 1'b1);
    run_jump(fcbu_pkg::OPC_JP_SIGN_SET, 16'hABCD, 1'b1);
    set_flags(1'b1, 1'b0, 1'b1, 8'h00);
    run_jump(fcbu_pkg::OPC_JP_SIGN_SET, 16'h8001, 1'b0);
  endtask

  // an unhandled jump opcode starts nothing
  task t_refused;
    @(posedge clk_sys); #1;
    instr_valid = 1'b1; instr_opcode = 8'h43; instr_addr = 16'h0200;
    repeat (4) begin
      @(posedge clk_sys); #1;
      chk("ignored", 16'h0000, {13'h0000, instr_busy, mem_rd_en, counter_load});
    end
    instr_valid = 1'b0;
  endtask

  // reset in mid-jump: the jump is dropped, outputs go to zero, the next jump runs whole
  task t_reset_mid;
    @(posedge clk_sys);
    #1;
    instr_valid = 1'b1;
    instr_opcode = fcbu_pkg::OPC_JP_NONZERO;
    instr_addr = 16'h0300;
    repeat (3) @(posedge clk_sys);
    #1;
    chk1("busy_before_reset", 1'b1, instr_busy);
    instr_valid = 1'b0;
    rstn = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk_idle("mid_reset");
    rstn = 1'b1;
    run_jump(fcbu_pkg::OPC_JP_SIGN_CLR, 16'h0500, 1'b1);
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    chk_idle("reset");
    rstn = 1'b1;
    t_sign_clear;
    t_nonzero;
    t_sign_set;
    t_refused;
    t_reset_mid;
    test_done;
  end
endmodule
